// ### verilog/slot_table_pkg.sv
/*
 * Constants, widths and state types for the waveform slot table loader.
 * Assumes command words arrive already deframed, one 16-bit word at a time.
 */
package slot_table_pkg;
  localparam int          WORD_W       = 16;
  localparam int          ADDR_W       = 10;
  localparam int          SLOT_IDX_W   = 4;
  localparam int          SLOT_COUNT   = 15;
  localparam logic [15:0] CMD_TABLE_LD = 16'h0002;
  localparam logic [3:0]  SLOT_FIRST   = 4'h0;
  localparam logic [3:0]  SLOT_LAST    = 4'hE;
  localparam logic [9:0]  ADDR_RESET   = 10'h000;
  localparam int          PTR_LSB      = 0;

  typedef enum logic [0:0] {
    LD_IDLE,
    LD_ENTRIES
  } loader_state_t;

  typedef enum logic [0:0] {
    PL_READY,
    PL_RUN
  } player_state_t;
endpackage

// ### verilog/slot_table_if.sv
/*
 * Carrier between the command side and the slot storage.
 * Assumes both ends share ref_clk_i and its clock enable.
 */
`timescale 1ns/1ps
interface slot_table_if;
  logic                                  wr_en;
  logic [slot_table_pkg::SLOT_IDX_W-1:0] wr_idx;
  logic [slot_table_pkg::ADDR_W-1:0]     wr_addr;
  logic [slot_table_pkg::SLOT_IDX_W-1:0] rd_idx;
  logic [slot_table_pkg::ADDR_W-1:0]     rd_addr;

  modport owner (
    output wr_en,
    output wr_idx,
    output wr_addr,
    output rd_idx,
    input  rd_addr
  );

  modport store (
    input  wr_en,
    input  wr_idx,
    input  wr_addr,
    input  rd_idx,
    output rd_addr
  );
endinterface

// ### verilog/slot_store.sv
/*
 * Fifteen-entry start-pointer storage with one write and one registered
 * read port. Assumes a synchronous active-low reset and a clock enable.
 */
`timescale 1ns/1ps
module slot_store (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  input  wire logic clk_en_i,
  // Table port
  slot_table_if.store tbl
);
  logic [slot_table_pkg::ADDR_W-1:0] mem_q [slot_table_pkg::SLOT_COUNT];
  logic [slot_table_pkg::ADDR_W-1:0] rd_addr_q;

  // Entries change only on a write strobe or reset
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < slot_table_pkg::SLOT_COUNT; i++) begin
        mem_q[i] <= slot_table_pkg::ADDR_RESET;
      end
    end else if (clk_en_i && tbl.wr_en) begin
      mem_q[tbl.wr_idx] <= tbl.wr_addr;
    end
  end

  // Old value on a same-slot write; the next cycle catches up
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rd_addr_q <= slot_table_pkg::ADDR_RESET;
    end else if (clk_en_i) begin
      rd_addr_q <= mem_q[tbl.rd_idx];
    end
  end

  assign tbl.rd_addr = rd_addr_q;

  property p_write_lands;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (clk_en_i && tbl.wr_en) |=> (mem_q[$past(tbl.wr_idx)]
                                  == $past(tbl.wr_addr));
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("slot entry not stored");

  property p_hold;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (!(clk_en_i && tbl.wr_en)) |=> (mem_q[0] == $past(mem_q[0]));
  endproperty
  a_hold: assert property (p_hold)
    else $error("slot 0 changed without a write");
endmodule

// ### verilog/waveform_slot_table_loader.sv
/*
 * Slot table loader and playlist stepper. Parses the table load command
 * from a deframed word stream, fills the slot table, and on arming walks
 * the slots from first to last, giving each wave start address.
 * Assumes word_first_i marks word 0 of every command frame.
 */
`timescale 1ns/1ps
module waveform_slot_table_loader (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        clk_en_i,
  // Command word stream
  input  wire logic        word_valid_i,
  input  wire logic        word_first_i,
  input  wire logic [15:0] word_i,
  // Arming
  input  wire logic        arm_valid_i,
  input  wire logic [3:0]  arm_first_i,
  input  wire logic [3:0]  arm_last_i,
  // Playback side
  input  wire logic        play_next_i,
  output logic             play_valid_o,
  output logic [3:0]       slot_index_o,
  output logic [9:0]       wave_addr_o,
  output logic             play_done_o,
  // Status
  output logic             load_busy_o,
  output logic             table_loaded_o
);
  slot_table_if tbl ();

  slot_store u_store (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .clk_en_i  (clk_en_i),
    .tbl       (tbl.store)
  );

  // Shared by both arming fields; 0xF is not a slot
  function automatic logic slot_ok(input logic [3:0] idx);
    slot_ok = (idx <= slot_table_pkg::SLOT_LAST);
  endfunction

  slot_table_pkg::loader_state_t ld_state_q;
  slot_table_pkg::player_state_t pl_state_q;
  logic [3:0] ld_cnt_q;
  logic [3:0] cur_q;
  logic [3:0] cur_d;
  logic [3:0] last_q;
  logic       loaded_q;
  logic       done_q;
  logic       open_cmd;
  logic       arm_ok;
  logic       step;
  logic       step_end;

  assign open_cmd = word_valid_i && word_first_i
                    && (word_i == slot_table_pkg::CMD_TABLE_LD);
  // Reversed or out-of-range arming is dropped, never flagged
  assign arm_ok   = arm_valid_i && slot_ok(arm_first_i)
                    && slot_ok(arm_last_i) && (arm_first_i <= arm_last_i);
  assign step     = (pl_state_q == slot_table_pkg::PL_RUN) && play_next_i;
  assign step_end = step && (cur_q == last_q);

  // Loader: word 0 opens, then fifteen entries in slot order
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      ld_state_q <= slot_table_pkg::LD_IDLE;
      ld_cnt_q   <= slot_table_pkg::SLOT_FIRST;
    end else if (clk_en_i && word_valid_i) begin
      if (word_first_i) begin
        // A new frame abandons any partial load
        ld_state_q <= open_cmd ? slot_table_pkg::LD_ENTRIES
                               : slot_table_pkg::LD_IDLE;
        ld_cnt_q   <= slot_table_pkg::SLOT_FIRST;
      end else if (ld_state_q == slot_table_pkg::LD_ENTRIES) begin
        if (ld_cnt_q == slot_table_pkg::SLOT_LAST) begin
          ld_state_q <= slot_table_pkg::LD_IDLE;
          ld_cnt_q   <= slot_table_pkg::SLOT_FIRST;
        end else begin
          ld_cnt_q <= ld_cnt_q + 4'h1;
        end
      end
    end
  end

  // Entry n-1 from data word n; upper bits ignored, no value refused
  assign tbl.wr_en   = clk_en_i && word_valid_i && !word_first_i
                       && (ld_state_q == slot_table_pkg::LD_ENTRIES);
  assign tbl.wr_idx  = ld_cnt_q;
  assign tbl.wr_addr = word_i[slot_table_pkg::PTR_LSB +:
                              slot_table_pkg::ADDR_W];

  // Pulse marks a complete table; an aborted load never raises it
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      loaded_q <= 1'b0;
    end else if (clk_en_i) begin
      loaded_q <= tbl.wr_en && (ld_cnt_q == slot_table_pkg::SLOT_LAST);
    end
  end

  // Player: index order from first to last armed slot
  always_comb begin
    cur_d = cur_q;
    if (arm_ok && (pl_state_q == slot_table_pkg::PL_READY)) begin
      cur_d = arm_first_i;
    end else if (step && !step_end) begin
      cur_d = cur_q + 4'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      pl_state_q <= slot_table_pkg::PL_READY;
      cur_q      <= slot_table_pkg::SLOT_FIRST;
      last_q     <= slot_table_pkg::SLOT_FIRST;
    end else if (clk_en_i) begin
      cur_q <= cur_d;
      case (pl_state_q)
        slot_table_pkg::PL_READY: begin
          if (arm_ok) begin
            pl_state_q <= slot_table_pkg::PL_RUN;
            last_q     <= arm_last_i;
          end
        end
        slot_table_pkg::PL_RUN: begin
          if (step_end) begin
            pl_state_q <= slot_table_pkg::PL_READY;
          end
        end
        default: pl_state_q <= slot_table_pkg::PL_READY;
      endcase
    end
  end

  // One-cycle pulse, so the engine may re-arm at once
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      done_q <= 1'b0;
    end else if (clk_en_i) begin
      done_q <= step_end;
    end
  end

  // Registered read is indexed by cur_d, so address and index stay paired
  assign tbl.rd_idx     = cur_d;
  assign wave_addr_o    = tbl.rd_addr;
  assign slot_index_o   = cur_q;
  assign play_valid_o   = (pl_state_q == slot_table_pkg::PL_RUN);
  assign play_done_o    = done_q;
  assign load_busy_o    = (ld_state_q == slot_table_pkg::LD_ENTRIES);
  assign table_loaded_o = loaded_q;

  property p_open;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (clk_en_i && open_cmd) |=> (load_busy_o && ld_cnt_q == 4'h0);
  endproperty
  a_open: assert property (p_open)
    else $error("table load not opened");

  property p_entry_write;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (clk_en_i && load_busy_o && word_valid_i && !word_first_i)
      |-> (tbl.wr_en && tbl.wr_idx == ld_cnt_q
           && tbl.wr_addr == word_i[9:0]);
  endproperty
  a_entry_write: assert property (p_entry_write)
    else $error("entry not written to its slot");

  property p_no_stray_write;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (!load_busy_o || word_first_i) |-> !tbl.wr_en;
  endproperty
  a_no_stray_write: assert property (p_no_stray_write)
    else $error("write outside a table load");

  property p_index_range;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (ld_cnt_q <= 4'hE) && (slot_index_o <= 4'hE);
  endproperty
  a_index_range: assert property (p_index_range)
    else $error("slot index beyond 0xE");

  property p_load_ends;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (clk_en_i && tbl.wr_en && ld_cnt_q == 4'hE)
      |=> (!load_busy_o && table_loaded_o) ##1 !table_loaded_o;
  endproperty
  a_load_ends: assert property (p_load_ends)
    else $error("load did not end after fifteen entries");

  property p_arm_start;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (clk_en_i && arm_ok && !play_valid_o)
      |=> (play_valid_o && slot_index_o == $past(arm_first_i));
  endproperty
  a_arm_start: assert property (p_arm_start)
    else $error("arming did not start at first slot");

  property p_advance;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (clk_en_i && step && !step_end)
      |=> (slot_index_o == $past(slot_index_o) + 4'h1 && play_valid_o);
  endproperty
  a_advance: assert property (p_advance)
    else $error("slot did not advance in index order");

  property p_finish;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (clk_en_i && step_end) |=> (play_done_o && !play_valid_o);
  endproperty
  a_finish: assert property (p_finish)
    else $error("last slot did not end playback");

  property p_freeze;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    !clk_en_i |=> ($stable(slot_index_o) && $stable(play_valid_o)
                   && $stable(load_busy_o) && $stable(wave_addr_o));
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");
endmodule

// ### testbench/host_model.sv
/*
 * Host side model: drives deframed command words into the slot table
 * loader, one word per cycle on the falling clock edge.
 * Assumes the caller waits for each frame task to return.
 */
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire logic   ref_clk_i,
  // Command word stream
  output logic        word_valid_o,
  output logic        word_first_o,
  output logic [15:0] word_o
);
  initial begin
    word_valid_o = 1'b0;
    word_first_o = 1'b0;
    word_o       = 16'h0000;
  end

  // Head word, then n entries back to back
  task automatic send_frame(input logic [15:0] head,
                            input logic [9:0]  ptr [15],
                            input int          n);
    @(negedge ref_clk_i);
    word_valid_o = 1'b1;
    word_first_o = 1'b1;
    word_o       = head;
    // Full loads pass n of 15; shorter only on purpose
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk_i);
      word_first_o = 1'b0;
      word_o       = {6'h00, ptr[i]};
    end
    @(negedge ref_clk_i);
    word_valid_o = 1'b0;
    // Released lines must not keep showing a stale word
    word_o       = ~word_o;
  endtask
endmodule

// ### testbench/waveform_slot_table_loader_bench.sv
/*
 * Self-checking bench for the waveform slot table loader.
 * Assumes the host model drives the word stream; arming and playback
 * handshakes are driven here on the falling edge.
 */
`timescale 1ns/1ps
module waveform_slot_table_loader_bench;
  logic        ref_clk_i = 1'b0;
  logic        rst_b_i   = 1'b0;
  logic        clk_en_i  = 1'b1;
  logic        arm_valid_i = 1'b0;
  logic [3:0]  arm_first_i = 4'h0;
  logic [3:0]  arm_last_i  = 4'h0;
  logic        play_next_i = 1'b0;
  logic        word_valid, word_first;
  logic [15:0] word;
  logic        play_valid_o, play_done_o, load_busy_o, table_loaded_o;
  logic [3:0]  slot_index_o;
  logic [9:0]  wave_addr_o;
  logic [9:0]  tbl [15];
  int          err_count   = 0;
  int          check_count = 0;

  always #10 ref_clk_i = ~ref_clk_i;

  host_model i_host_model (
    .ref_clk_i    (ref_clk_i),
    .word_valid_o (word_valid),
    .word_first_o (word_first),
    .word_o       (word)
  );

  waveform_slot_table_loader i_waveform_slot_table_loader (
    .ref_clk_i      (ref_clk_i),
    .rst_b_i        (rst_b_i),
    .clk_en_i       (clk_en_i),
    .word_valid_i   (word_valid),
    .word_first_i   (word_first),
    .word_i         (word),
    .arm_valid_i    (arm_valid_i),
    .arm_first_i    (arm_first_i),
    .arm_last_i     (arm_last_i),
    .play_next_i    (play_next_i),
    .play_valid_o   (play_valid_o),
    .slot_index_o   (slot_index_o),
    .wave_addr_o    (wave_addr_o),
    .play_done_o    (play_done_o),
    .load_busy_o    (load_busy_o),
    .table_loaded_o (table_loaded_o)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic reset_dut;
    rst_b_i = 1'b0;
    repeat (5) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    for (int i = 0; i < 15; i++)
      tbl[i] = 10'h000;
  endtask

  task automatic load_table(input logic [9:0] base);
    for (int i = 0; i < 15; i++)
      tbl[i] = base + 10'(i * 37);
    fork
      i_host_model.send_frame(16'h0002, tbl, 15);
      begin
        repeat (2) @(negedge ref_clk_i);
        chk(16'(load_busy_o), 16'h0001);
      end
    join
    chk(16'(table_loaded_o), 16'h0001);
    chk(16'(load_busy_o), 16'h0000);
    @(negedge ref_clk_i);
    chk(16'(table_loaded_o), 16'h0000);
  endtask

  task automatic play_range(input logic [3:0] first, input logic [3:0] last);
    @(negedge ref_clk_i);
    arm_valid_i = 1'b1;
    arm_first_i = first;
    arm_last_i  = last;
    @(negedge ref_clk_i);
    arm_valid_i = 1'b0;
    for (int i = first; i <= last; i++) begin
      chk(16'(play_valid_o), 16'h0001);
      chk(16'(slot_index_o), 16'(i));
      chk(16'(wave_addr_o), 16'(tbl[i]));
      play_next_i = 1'b1;
      @(negedge ref_clk_i);
    end
    play_next_i = 1'b0;
    chk(16'(play_valid_o), 16'h0000);
    chk(16'(play_done_o), 16'h0001);
    @(negedge ref_clk_i);
    chk(16'(play_done_o), 16'h0000);
  endtask

  // Wrong head code, bad arming ranges; table must stay intact
  task automatic refused_requests;
    logic [9:0] junk [15];
    for (int i = 0; i < 15; i++)
      junk[i] = 10'h3FF;
    i_host_model.send_frame(16'h0012, junk, 2);
    chk(16'(load_busy_o), 16'h0000);
    chk(16'(table_loaded_o), 16'h0000);
    @(negedge ref_clk_i);
    arm_valid_i = 1'b1;
    arm_first_i = 4'h5;
    arm_last_i  = 4'h3;
    @(negedge ref_clk_i);
    arm_first_i = 4'h0;
    arm_last_i  = 4'hF;
    chk(16'(play_valid_o), 16'h0000);
    @(negedge ref_clk_i);
    arm_valid_i = 1'b0;
    chk(16'(play_valid_o), 16'h0000);
    play_range(4'h2, 4'h4);
  endtask

  // Words offered with the clock enable low must change nothing
  task automatic frozen_load;
    logic [9:0] junk [15];
    for (int i = 0; i < 15; i++)
      junk[i] = 10'h155;
    @(negedge ref_clk_i);
    clk_en_i = 1'b0;
    i_host_model.send_frame(16'h0002, junk, 15);
    chk(16'(load_busy_o), 16'h0000);
    chk(16'(table_loaded_o), 16'h0000);
    clk_en_i = 1'b1;
    play_range(4'h0, 4'hE);
  endtask

  initial begin
    #100us;
    err_count++;
    conclude();
  end

  initial begin
    reset_dut();
    load_table(10'h005);
    play_range(4'h0, 4'hE);
    refused_requests();
    // Second load must replace every entry
    load_table(10'h2A0);
    play_range(4'hD, 4'hE);
    play_range(4'h7, 4'h7);
    frozen_load();
    reset_dut();
    play_range(4'h0, 4'hE);
    conclude();
  end
endmodule
